//--- core/wdt_index_port.sv
`timescale 1ns/1ps
`default_nettype none
module wdt_index_port #(
   parameter int SEC_DIV = wdt_pkg::SEC_CYCLES
)(
   // clock and reset
   input  wire logic       i_mclk,
   input  wire logic       i_rst_b,
   // host i/o cycle
   input  wire logic       i_io_wr,
   input  wire logic       i_io_rd,
   input  wire logic [7:0] i_io_addr,
   input  wire logic [7:0] i_io_wdata,
   output logic      [7:0] o_io_rdata,
   output logic            o_io_rvalid,
   // status and reset request
   output logic            o_running,
   output logic            o_sys_reset
);
   import wdt_pkg::*;

   //------------------------------------------------------------
   // reset release
   //------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_n;

   // asynchronous assert, two-flop synchronous release
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   //------------------------------------------------------------
   // configuration access decode
   //------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_LOCKED = 3'b001,
      ST_HALF   = 3'b010,
      ST_OPEN   = 3'b100
   } lock_e;

   lock_e       lock_reg;
   lock_e       lock_next;
   logic [7:0]  index_reg;
   logic [7:0]  ldn_reg;
   logic [7:0]  activate_reg;
   logic [7:0]  timebase_reg;
   logic [7:0]  count_reg;
   logic        unlocked;
   logic        wr_index;
   logic        wr_data;
   logic        rd_data;
   logic        ldn_hit;
   logic        wr_ldn;
   logic        wr_act;
   logic        wr_tb;
   logic        wr_cnt;
   logic [7:0]  rd_mux;

   assign unlocked = (lock_reg == ST_OPEN);
   assign wr_index = i_io_wr && (i_io_addr == INDEX_PORT);
   assign wr_data  = i_io_wr && (i_io_addr == DATA_PORT) && unlocked;
   assign rd_data  = i_io_rd && (i_io_addr == DATA_PORT) && unlocked;
   assign ldn_hit  = (ldn_reg == WDT_LDN);
   assign wr_ldn   = wr_data && (index_reg == IDX_LDN_SEL);
   assign wr_act   = wr_data && ldn_hit && (index_reg == IDX_ACTIVATE);
   assign wr_tb    = wr_data && ldn_hit && (index_reg == IDX_TIMEBASE);
   assign wr_cnt   = wr_data && ldn_hit && (index_reg == IDX_COUNT);

   // unlock key twice in a row opens, lock key closes
   always_comb
   begin
      lock_next = lock_reg;
      if (wr_index)
      begin
         unique case (lock_reg)
            ST_LOCKED : lock_next = (i_io_wdata == UNLOCK_KEY) ? ST_HALF : ST_LOCKED;
            ST_HALF   : lock_next = (i_io_wdata == UNLOCK_KEY) ? ST_OPEN : ST_LOCKED;
            ST_OPEN   : lock_next = (i_io_wdata == LOCK_KEY) ? ST_LOCKED : ST_OPEN;
            default   : lock_next = ST_LOCKED;
         endcase
      end
   end

   // index/data selection for reads; other devices read as zero
   assign rd_mux = (index_reg == IDX_LDN_SEL)            ? ldn_reg      :
                   (ldn_hit && index_reg == IDX_ACTIVATE) ? activate_reg :
                   (ldn_hit && index_reg == IDX_TIMEBASE) ? timebase_reg :
                   (ldn_hit && index_reg == IDX_COUNT)    ? count_reg    : 8'h00;

   // lock state and index latch
   always_ff @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lock_reg  <= ST_LOCKED;
         index_reg <= 8'h00;
      end
      else
      begin
         lock_reg <= lock_next;
         if (wr_index && unlocked)
            index_reg <= i_io_wdata;
      end
   end

   // configuration registers
   always_ff @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ldn_reg      <= RST_LDN;
         activate_reg <= RST_ACTIVATE;
         timebase_reg <= RST_TIMEBASE;
      end
      else
      begin
         if (wr_ldn)
            ldn_reg <= i_io_wdata;
         if (wr_act)
            activate_reg <= i_io_wdata;
         if (wr_tb)
            timebase_reg <= i_io_wdata;
      end
   end

   // read data returns one cycle after the strobe
   always_ff @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_io_rdata  <= 8'h00;
         o_io_rvalid <= 1'b0;
      end
      else
      begin
         o_io_rvalid <= rd_data;
         o_io_rdata  <= rd_data ? rd_mux : 8'h00;
      end
   end

   //------------------------------------------------------------
   // countdown
   //------------------------------------------------------------
   tick_if tk ();

   wdt_prescaler #(
      .SEC_DIV (SEC_DIV)
   ) u_prescaler (
      .i_clk   (i_mclk),
      .i_rst_n (rst_n),
      .tk      (tk)
   );

   logic       enabled;
   logic       minute_mode;
   logic       unit_tick;
   logic       expire;
   logic [7:0] remain_reg;
   logic [7:0] rst_cnt_reg;

   assign enabled     = activate_reg[0];
   assign minute_mode = timebase_reg[TB_MIN_BIT];
   assign unit_tick   = minute_mode ? tk.min_tick : tk.sec_tick;
   assign tk.restart  = wr_cnt || !enabled;
   assign expire      = enabled && (remain_reg == 8'h01) && unit_tick;

   // count register keeps the preset, remain_reg holds remaining units; reload restarts it
   always_ff @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_reg  <= RST_COUNT;
         remain_reg <= RST_COUNT;
      end
      else if (wr_cnt)
      begin
         count_reg  <= i_io_wdata;
         remain_reg <= i_io_wdata;
      end
      else if (enabled && remain_reg != 8'h00 && unit_tick)
      begin
         remain_reg <= remain_reg - 8'h01;
      end
   end

   // reset pulse stretched so the board reset logic catches it
   always_ff @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_cnt_reg <= 8'h00;
         o_sys_reset <= 1'b0;
         o_running   <= 1'b0;
      end
      else
      begin
         if (expire)
            rst_cnt_reg <= 8'(RESET_CYCLES);
         else if (rst_cnt_reg != 8'h00)
            rst_cnt_reg <= rst_cnt_reg - 8'h01;
         o_sys_reset <= expire || (rst_cnt_reg > 8'h01);
         // zero count or inactive unit means no timeout
         o_running   <= enabled && (remain_reg != 8'h00);
      end
   end

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   a_disable_stops: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (wr_act && i_io_wdata == 8'h00) |=> ##1 !o_running)
      else $error("unit still running after disable");

   a_zero_disables: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (wr_cnt && i_io_wdata == 8'h00) |=> !expire)
      else $error("zero count expired");

   a_reload_restart: assert property (@(posedge i_mclk) disable iff (!rst_n)
      wr_cnt |=> (remain_reg == $past(i_io_wdata)))
      else $error("reload did not restart count");

   a_expire_reset: assert property (@(posedge i_mclk) disable iff (!rst_n)
      expire |=> o_sys_reset)
      else $error("no reset on expiry");

   a_locked_nowrite: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (lock_reg != ST_OPEN && i_io_wr) |=> $stable(ldn_reg))
      else $error("write accepted while locked");

   a_minute_tick: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (minute_mode && tk.sec_tick && !tk.min_tick && !wr_cnt && enabled)
      |=> $stable(remain_reg))
      else $error("minute mode counted a second");

   a_second_tick: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (!minute_mode && tk.sec_tick && enabled && !wr_cnt && remain_reg > 8'h01)
      |=> (remain_reg == $past(remain_reg) - 8'h01))
      else $error("seconds mode missed a unit");

   a_read_answer: assert property (@(posedge i_mclk) disable iff (!rst_n)
      rd_data |=> o_io_rvalid && (o_io_rdata == $past(rd_mux)))
      else $error("data port read wrong");

   //------------------------------------------------------------
   // lock, select and pulse checks
   //------------------------------------------------------------
   // the lock key must close the port while it is fully open
   a_lock_key_closes: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (wr_index && unlocked && i_io_wdata == LOCK_KEY) |=> (lock_reg == ST_LOCKED))
      else $error("lock key did not close the port");

   // index latch must not move while the port is closed
   a_locked_index: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (!unlocked && wr_index) |=> $stable(index_reg))
      else $error("index moved while locked");

   // another selected device must never reach the activate register
   a_other_ldn_quiet: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (wr_data && !ldn_hit && index_reg == IDX_ACTIVATE) |=> $stable(activate_reg))
      else $error("activate written for another device");

   // time base takes the written value as is
   a_timebase_write: assert property (@(posedge i_mclk) disable iff (!rst_n)
      wr_tb |=> (timebase_reg == $past(i_io_wdata)))
      else $error("time base write lost");

   // running flag follows enable and remaining count one cycle later
   a_running_level: assert property (@(posedge i_mclk) disable iff (!rst_n)
      1'b1 |=> (o_running == $past(enabled && remain_reg != 8'h00)))
      else $error("running flag wrong");

   // count only moves on a reload or a unit tick
   a_count_hold: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (!wr_cnt && !unit_tick) |=> $stable(remain_reg))
      else $error("count moved without a tick");

   // a pulse shorter than a few cycles could be missed by the board
   a_pulse_holds: assert property (@(posedge i_mclk) disable iff (!rst_n)
      $rose(o_sys_reset) |=> o_sys_reset [*8])
      else $error("reset pulse too short");

   // no reset request without a preceding expiry
   a_no_stray_reset: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (!expire && rst_cnt_reg <= 8'h01) |=> !o_sys_reset)
      else $error("reset raised without expiry");

endmodule
`default_nettype wire

//--- core/wdt_pkg.sv
// Summary of operation
// - count down from preset, reset at zero
// - each reload restarts countdown from preset
// - index port then data port access
// - time base value 00h selects seconds
// - time base value 08h selects minutes
// - count 1..255 seconds, zero disables
// - count 1..255 minutes in minutes mode
// - activate 00h disables at any time
package wdt_pkg;

   //------------------------------------------------------------
   // host port addresses and keys
   //------------------------------------------------------------
   localparam logic [7:0] INDEX_PORT     = 8'h2e;
   localparam logic [7:0] DATA_PORT      = 8'h2f;
   localparam logic [7:0] UNLOCK_KEY     = 8'h87;
   localparam logic [7:0] LOCK_KEY       = 8'haa;
   localparam logic [7:0] WDT_LDN        = 8'h08;

   //------------------------------------------------------------
   // register indices and values
   //------------------------------------------------------------
   localparam logic [7:0] IDX_LDN_SEL    = 8'h07;
   localparam logic [7:0] IDX_ACTIVATE   = 8'h30;
   localparam logic [7:0] IDX_TIMEBASE   = 8'hf5;
   localparam logic [7:0] IDX_COUNT      = 8'hf6;
   localparam logic [7:0] TB_SECONDS     = 8'h00;
   localparam logic [7:0] TB_MINUTES     = 8'h08;
   localparam logic [7:0] RST_LDN        = 8'h00;
   localparam logic [7:0] RST_ACTIVATE   = 8'h00;
   localparam logic [7:0] RST_TIMEBASE   = 8'h00;
   localparam logic [7:0] RST_COUNT      = 8'h00;
   localparam int         TB_MIN_BIT     = 3;

   //------------------------------------------------------------
   // timing
   //------------------------------------------------------------
   localparam int CLK_HZ         = 125_000_000;
   localparam int SECOND_S       = 1;
   localparam int SEC_CYCLES     = CLK_HZ * SECOND_S;
   localparam int MIN_SECONDS    = 60;
   localparam int RESET_PULSE_NS = 1000;
   localparam int RESET_CYCLES   = (RESET_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

endpackage

//--- core/tick_if.sv
`timescale 1ns/1ps
`default_nettype none
// time base pulses shared between the prescaler and the counter
interface tick_if;
   logic sec_tick;
   logic min_tick;
   logic restart;
   modport gen (output sec_tick, output min_tick, input restart);
   modport use_ (input sec_tick, input min_tick, output restart);
endinterface
`default_nettype wire

//--- core/wdt_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module wdt_prescaler #(
   parameter int SEC_DIV = 125_000_000
)(
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   // tick outputs
   tick_if.gen       tk
);
   import wdt_pkg::*;

   logic [31:0] sec_cnt_reg;
   logic [5:0]  min_cnt_reg;
   logic        sec_wrap;
   logic        min_wrap;

   assign sec_wrap = (sec_cnt_reg == 32'(SEC_DIV - 1));
   assign min_wrap = sec_wrap && (min_cnt_reg == 6'(MIN_SECONDS - 1));

   // restart aligns the first unit to a full period after reload
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sec_cnt_reg <= '0;
         min_cnt_reg <= '0;
         tk.sec_tick <= 1'b0;
         tk.min_tick <= 1'b0;
      end
      else if (tk.restart)
      begin
         sec_cnt_reg <= '0;
         min_cnt_reg <= '0;
         tk.sec_tick <= 1'b0;
         tk.min_tick <= 1'b0;
      end
      else
      begin
         sec_cnt_reg <= sec_wrap ? '0 : sec_cnt_reg + 32'd1;
         if (sec_wrap)
            min_cnt_reg <= min_wrap ? '0 : min_cnt_reg + 6'd1;
         tk.sec_tick <= sec_wrap;
         tk.min_tick <= min_wrap;
      end
   end
endmodule
`default_nettype wire

//--- verification/watchdog_index_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module watchdog_index_port_bench;
   import wdt_pkg::*;

   // ----------------------------------------
   // clock, reset and design under test
   // ----------------------------------------
   localparam int UNIT = 10;  // short second keeps the minute run near 600 cycles
   logic       i_mclk = 1'b0;
   logic       i_rst_b = 1'b0;
   logic       i_io_wr = 1'b0;
   logic       i_io_rd = 1'b0;
   logic [7:0] i_io_addr = 8'h00;
   logic [7:0] i_io_wdata = 8'h00;
   logic [7:0] o_io_rdata;
   logic       o_io_rvalid;
   logic       o_running;
   logic       o_sys_reset;
   int         mismatches = 0;
   int         checked = 0;

   always #4 i_mclk = ~i_mclk;

   wdt_index_port #(.SEC_DIV(UNIT)) i_wdt_index_port (
      .i_mclk      (i_mclk),
      .i_rst_b     (i_rst_b),
      .i_io_wr     (i_io_wr),
      .i_io_rd     (i_io_rd),
      .i_io_addr   (i_io_addr),
      .i_io_wdata  (i_io_wdata),
      .o_io_rdata  (o_io_rdata),
      .o_io_rvalid (o_io_rvalid),
      .o_running   (o_running),
      .o_sys_reset (o_sys_reset)
   );

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // one idle edge between strobes so no signal is set twice in a time step
   task automatic io_write(input logic [7:0] addr, input logic [7:0] data);
      @(posedge i_mclk);
      #1;
      i_io_wr = 1'b1;
      i_io_addr = addr;
      i_io_wdata = data;
      @(posedge i_mclk);
      #1;
      i_io_wr = 1'b0;
   endtask

   task automatic reg_write(input logic [7:0] idx, input logic [7:0] data);
      io_write(INDEX_PORT, idx);
      io_write(DATA_PORT, data);
   endtask

   // answer stands in the cycle after the strobe edge, sampled there
   task automatic reg_read(input logic [7:0] idx, output logic [7:0] d, output logic v);
      io_write(INDEX_PORT, idx);
      @(posedge i_mclk);
      #1;
      i_io_rd = 1'b1;
      i_io_addr = DATA_PORT;
      @(posedge i_mclk);
      #1;
      i_io_rd = 1'b0;
      d = o_io_rdata;
      v = o_io_rvalid;
   endtask

   task automatic read_expect(input logic [7:0] idx, input logic [7:0] exp, input string msg);
      logic [7:0] d;
      logic       v;
      reg_read(idx, d, v);
      check({7'h00, v}, 8'h01, msg);
      check(d, exp, msg);
   endtask

   task automatic open_device();
      io_write(INDEX_PORT, UNLOCK_KEY);
      io_write(INDEX_PORT, UNLOCK_KEY);
      reg_write(IDX_LDN_SEL, WDT_LDN);
   endtask

   // expiry must land near the expected cycle, then a pulse of fixed width
   task automatic expect_timeout(input int cyc, input string msg);
      int cnt;
      int width;
      cnt = 0;
      width = 0;
      while (o_sys_reset !== 1'b1 && cnt < cyc + 6)
      begin
         @(posedge i_mclk);
         #1;
         cnt++;
      end
      check({7'h00, cnt >= cyc - 2 && cnt <= cyc + 3}, 8'h01, msg);
      while (o_sys_reset === 1'b1 && width < 300)
      begin
         @(posedge i_mclk);
         #1;
         width++;
      end
      check(width[7:0], RESET_CYCLES[7:0], "reset pulse width");
   endtask

   task automatic expect_quiet(input int cyc, input string msg);
      int hits;
      hits = 0;
      repeat (cyc)
      begin
         @(posedge i_mclk);
         #1;
         if (o_sys_reset !== 1'b0)
            hits++;
      end
      check(hits[7:0], 8'h00, msg);
      check({7'h00, o_running}, 8'h00, {msg, " running"});
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_locked_and_defaults();
      logic [7:0] d;
      logic       v;
      reg_read(IDX_LDN_SEL, d, v);
      check({7'h00, v}, 8'h00, "locked read answered");
      open_device();
      read_expect(IDX_LDN_SEL, WDT_LDN, "select readback");
      read_expect(IDX_ACTIVATE, RST_ACTIVATE, "activate reset");
      read_expect(IDX_TIMEBASE, RST_TIMEBASE, "timebase reset");
      read_expect(IDX_COUNT, RST_COUNT, "count reset");
   endtask

   task automatic test_seconds();
      reg_write(IDX_ACTIVATE, 8'h01);
      reg_write(IDX_TIMEBASE, TB_SECONDS);
      reg_write(IDX_COUNT, 8'h03);
      repeat (3) @(posedge i_mclk);
      #1;
      check({7'h00, o_running}, 8'h01, "running after load");
      expect_timeout(3 * UNIT, "seconds expiry");
      read_expect(IDX_COUNT, 8'h03, "count readback");
   endtask

   task automatic test_reload();
      reg_write(IDX_COUNT, 8'h03);
      repeat (20) @(posedge i_mclk);
      reg_write(IDX_COUNT, 8'h03);
      expect_timeout(3 * UNIT, "expiry after reload");
   endtask

   task automatic test_disables();
      reg_write(IDX_COUNT, 8'h00);
      expect_quiet(5 * UNIT, "count zero");
      reg_write(IDX_COUNT, 8'h02);
      repeat (5) @(posedge i_mclk);
      reg_write(IDX_ACTIVATE, 8'h00);
      expect_quiet(5 * UNIT, "deactivated mid run");
   endtask

   task automatic test_minutes();
      reg_write(IDX_ACTIVATE, 8'h01);
      reg_write(IDX_TIMEBASE, TB_MINUTES);
      read_expect(IDX_TIMEBASE, TB_MINUTES, "timebase readback");
      reg_write(IDX_COUNT, 8'h01);
      expect_timeout(MIN_SECONDS * UNIT, "minute expiry");
   endtask

   task automatic test_other_device();
      logic [7:0] d;
      logic       v;
      // unit is still active from the minute run, so a leaked clear would show
      reg_write(IDX_LDN_SEL, 8'h01);
      reg_write(IDX_ACTIVATE, 8'h00);
      read_expect(IDX_ACTIVATE, 8'h00, "other device activate");
      reg_write(IDX_LDN_SEL, WDT_LDN);
      read_expect(IDX_ACTIVATE, 8'h01, "write leaked through");
      io_write(INDEX_PORT, LOCK_KEY);
      reg_read(IDX_COUNT, d, v);
      check({7'h00, v}, 8'h00, "relocked read answered");
   endtask

   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      repeat (20) @(posedge i_mclk);
      #1;
      i_rst_b = 1'b1;
      repeat (4) @(posedge i_mclk);
      test_locked_and_defaults();
      test_seconds();
      test_reload();
      test_disables();
      test_minutes();
      test_other_device();
      stop_test();
   end

   initial
   begin
      #60000;
      mismatches++;
      stop_test();
   end

endmodule
`default_nettype wire
